// ==== output_channel_pkg.sv ====
package output_channel_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Bus geometry
	localparam int unsigned addr_width = 14;
	localparam int unsigned data_width = 32;
	localparam int unsigned index_width = 12;
	localparam int unsigned index_lsb = 2;

	////////////////////////////////////////////////////////////////////////////////
	// Register indices, byte address is four times the index
	localparam logic [11:0] idx_sync_mask = 12'h436;
	localparam logic [11:0] idx_channel_state = 12'h437;
	localparam logic [11:0] idx_output_b_mode_polarity = 12'h43b;
	localparam logic [11:0] idx_channel_b_divide_low = 12'h43c;
	localparam logic [11:0] idx_channel_b_divide_high = 12'h43d;
	localparam logic [11:0] idx_channel_b_start_phase = 12'h43e;

	////////////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int unsigned invert_bit = 0;
	localparam int unsigned mode_lsb = 1;
	localparam int unsigned mode_msb = 2;
	localparam int unsigned divide_low_msb = 7;
	localparam int unsigned divide_high_msb = 1;
	localparam int unsigned divide_split = 8;
	localparam int unsigned phase_msb = 5;
	localparam int unsigned sync_mask_bit = 1;
	localparam int unsigned state_held_bit = 0;
	localparam int unsigned state_running_bit = 1;
	localparam int unsigned state_enabled_bit = 2;

	////////////////////////////////////////////////////////////////////////////////
	// Widths and reset values
	localparam int unsigned ratio_width = 10;
	localparam int unsigned phase_width = 6;
	localparam logic [9:0] ratio_reset = 10'h000;
	localparam logic [5:0] phase_reset = 6'h00;

	////////////////////////////////////////////////////////////////////////////////
	// Bus responses
	localparam logic [1:0] resp_okay = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;

	////////////////////////////////////////////////////////////////////////////////
	// Modes and states
	typedef enum logic [1:0] {
		drive_low = 2'b00,
		drive_mid = 2'b01,
		drive_high = 2'b10,
		drive_off = 2'b11
	} drive_mode_type;

	typedef enum logic [1:0] {
		st_held = 2'b00,
		st_delay = 2'b01,
		st_run = 2'b10
	} divider_state_type;

	typedef struct packed {
		drive_mode_type mode;
		logic invert;
		logic [9:0] ratio;
		logic [5:0] phase;
		logic sync_mask;
	} channel_config_type;

	typedef struct packed {
		logic [1:0] pos;
		logic [1:0] neg;
		logic enable;
		drive_mode_type level;
	} driver_type;

endpackage

// ==== channel_divider_core.sv ====
`timescale 1ns/1ps
module channel_divider_core
	import output_channel_pkg::*;
#(
	parameter int unsigned RATIO_W = 10,
	parameter int unsigned PHASE_W = 6
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic hold,
	input wire logic [RATIO_W-1:0] ratio,
	input wire logic [PHASE_W-1:0] phase,
	output logic [1:0] halves,
	output logic running
);

	divider_state_type state;
	divider_state_type next_state;
	logic [RATIO_W+1:0] pos;
	logic [RATIO_W+1:0] next_pos;
	logic [PHASE_W-1:0] delay;
	logic [PHASE_W-1:0] next_delay;
	logic [1:0] next_halves;

	////////////////////////////////////////////////////////////////////////////////
	// Two half periods of the input clock per cycle
	always_comb begin
		logic [RATIO_W+1:0] p;
		logic [RATIO_W+1:0] limit;
		logic [RATIO_W+1:0] period;
		logic [PHASE_W-1:0] d;
		p = pos;
		d = delay;
		limit = {2'b00, ratio} + {{(RATIO_W+1){1'b0}}, 1'b1};
		period = {limit[RATIO_W:0], 1'b0};
		next_halves = 2'b00;
		next_state = state;
		if (hold) begin
			next_state = st_held;
			p = '0;
			d = phase;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (d != '0) begin
					next_halves[i] = 1'b0;
					d = d - {{(PHASE_W-1){1'b0}}, 1'b1};
				end else begin
					next_halves[i] = (p < limit);
					if (p + {{(RATIO_W+1){1'b0}}, 1'b1} >= period) begin
						p = '0;
					end else begin
						p = p + {{(RATIO_W+1){1'b0}}, 1'b1};
					end
				end
			end
			next_state = (d != '0) ? st_delay : st_run;
		end
		next_pos = p;
		next_delay = d;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= st_held;
			pos <= '0;
			delay <= '0;
			halves <= 2'b00;
			running <= 1'b0;
		end else begin
			state <= next_state;
			pos <= next_pos;
			delay <= next_delay;
			halves <= next_halves;
			running <= (next_state == st_run);
		end
	end

endmodule

// ==== channel_output_stage.sv ====
`timescale 1ns/1ps
module channel_output_stage
	import output_channel_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire drive_mode_type mode,
	input wire logic invert,
	input wire logic [1:0] halves,
	output driver_type drive
);

	driver_type next_drive;

	always_comb begin
		next_drive.level = mode;
		case (mode)
			drive_off: begin
				next_drive.pos = 2'b00;
				next_drive.neg = 2'b00;
				next_drive.enable = 1'b0;
			end
			drive_low, drive_mid, drive_high: begin
				next_drive.pos = halves ^ {2{invert}};
				next_drive.neg = ~(halves ^ {2{invert}});
				next_drive.enable = 1'b1;
			end
			default: begin
				next_drive.pos = 2'b00;
				next_drive.neg = 2'b00;
				next_drive.enable = 1'b0;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			drive <= '{pos: 2'b00, neg: 2'b00, enable: 1'b0, level: drive_low};
		end else begin
			drive <= next_drive;
		end
	end

endmodule

// ==== output_channel_divider.sv ====
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// How it works
// - Mode codes 00/01/10 pick drive level
// - Mode 11 powers down, tristates both outputs
// - Polarity bit set inverts output clock
// - Divide input clock by value plus one
// - Low eight bits, then two high bits
// - Start phase in input half periods
// - Sync reset holds divider; mask releases it
module output_channel_divider
	import output_channel_pkg::*;
#(
	parameter int unsigned RATIO_W = 10,
	parameter int unsigned PHASE_W = 6
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic sync_reset,
	input wire logic [13:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [13:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [1:0] output_channel_b_pos,
	output logic [1:0] output_channel_b_neg,
	output logic output_channel_b_oe,
	output logic [1:0] output_channel_b_level
);

	////////////////////////////////////////////////////////////////////////////////
	// Configuration state
	channel_config_type cfg;
	channel_config_type next_cfg;
	logic hold;
	logic [1:0] halves;
	logic running;
	driver_type drive;

	////////////////////////////////////////////////////////////////////////////////
	// Bus state
	logic aw_held;
	logic next_aw_held;
	logic [index_width-1:0] aw_index;
	logic [index_width-1:0] next_aw_index;
	logic w_held;
	logic next_w_held;
	logic [7:0] w_byte;
	logic [7:0] next_w_byte;
	logic w_lane;
	logic next_w_lane;
	logic next_awready;
	logic next_wready;
	logic next_bvalid;
	logic [1:0] next_bresp;
	logic next_arready;
	logic next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;

	////////////////////////////////////////////////////////////////////////////////
	// Address decode
	function automatic logic mapped(input logic [index_width-1:0] idx);
		mapped = (idx == idx_sync_mask) || (idx == idx_channel_state) ||
			(idx == idx_output_b_mode_polarity) || (idx == idx_channel_b_divide_low) ||
			(idx == idx_channel_b_divide_high) || (idx == idx_channel_b_start_phase);
	endfunction

	function automatic logic [31:0] read_value(input logic [index_width-1:0] idx,
			input channel_config_type c, input logic held, input logic run,
			input logic enabled);
		logic [31:0] v;
		v = 32'h00000000;
		case (idx)
			idx_sync_mask: begin
				v[sync_mask_bit] = c.sync_mask;
			end
			idx_channel_state: begin
				v[state_held_bit] = held;
				v[state_running_bit] = run;
				v[state_enabled_bit] = enabled;
			end
			idx_output_b_mode_polarity: begin
				v[mode_msb:mode_lsb] = c.mode;
				v[invert_bit] = c.invert;
			end
			idx_channel_b_divide_low: begin
				v[divide_low_msb:0] = c.ratio[divide_split-1:0];
			end
			idx_channel_b_divide_high: begin
				v[divide_high_msb:0] = c.ratio[RATIO_W-1:divide_split];
			end
			idx_channel_b_start_phase: begin
				v[phase_msb:0] = c.phase;
			end
			default: begin
				v = 32'h00000000;
			end
		endcase
		read_value = v;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Write channel
	always_comb begin
		next_aw_held = aw_held;
		next_aw_index = aw_index;
		next_w_held = w_held;
		next_w_byte = w_byte;
		next_w_lane = w_lane;
		next_bvalid = s_axi_bvalid;
		next_bresp = s_axi_bresp;
		next_cfg = cfg;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_aw_index = s_axi_awaddr[addr_width-1:index_lsb];
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held = 1'b1;
			next_w_byte = s_axi_wdata[7:0];
			next_w_lane = s_axi_wstrb[0];
		end
		if (aw_held && w_held && !s_axi_bvalid) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = mapped(aw_index) ? resp_okay : resp_slverr;
			if (w_lane) begin
				case (aw_index)
					idx_sync_mask: begin
						next_cfg.sync_mask = w_byte[sync_mask_bit];
					end
					idx_output_b_mode_polarity: begin
						next_cfg.mode = drive_mode_type'(w_byte[mode_msb:mode_lsb]);
						next_cfg.invert = w_byte[invert_bit];
					end
					idx_channel_b_divide_low: begin
						next_cfg.ratio[divide_split-1:0] = w_byte[divide_low_msb:0];
					end
					idx_channel_b_divide_high: begin
						next_cfg.ratio[RATIO_W-1:divide_split] = w_byte[divide_high_msb:0];
					end
					idx_channel_b_start_phase: begin
						next_cfg.phase = w_byte[phase_msb:0];
					end
					default: begin
						next_cfg = cfg;
					end
				endcase
			end
		end
		if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		next_awready = !next_aw_held && !next_bvalid;
		next_wready = !next_w_held && !next_bvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_index <= '0;
			w_held <= 1'b0;
			w_byte <= 8'h00;
			w_lane <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= resp_okay;
			cfg <= '{mode: drive_low, invert: 1'b0, ratio: ratio_reset,
				phase: phase_reset, sync_mask: 1'b0};
		end else begin
			aw_held <= next_aw_held;
			aw_index <= next_aw_index;
			w_held <= next_w_held;
			w_byte <= next_w_byte;
			w_lane <= next_w_lane;
			s_axi_awready <= next_awready;
			s_axi_wready <= next_wready;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			cfg <= next_cfg;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read channel
	always_comb begin
		next_arready = s_axi_arready;
		next_rvalid = s_axi_rvalid;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		if (s_axi_arvalid && s_axi_arready) begin
			next_arready = 1'b0;
			next_rvalid = 1'b1;
			next_rdata = read_value(s_axi_araddr[addr_width-1:index_lsb], cfg, hold,
				running, drive.enable);
			next_rresp = mapped(s_axi_araddr[addr_width-1:index_lsb]) ?
				resp_okay : resp_slverr;
		end else if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
			next_arready = 1'b1;
		end else if (!s_axi_rvalid) begin
			next_arready = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= resp_okay;
		end else begin
			s_axi_arready <= next_arready;
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Channel datapath
	assign hold = sync_reset && !cfg.sync_mask;

	channel_divider_core #(
		.RATIO_W(RATIO_W),
		.PHASE_W(PHASE_W)
	) u_divider (
		.aclk(aclk),
		.aresetn(aresetn),
		.hold(hold),
		.ratio(cfg.ratio),
		.phase(cfg.phase),
		.halves(halves),
		.running(running)
	);

	channel_output_stage u_stage (
		.aclk(aclk),
		.aresetn(aresetn),
		.mode(cfg.mode),
		.invert(cfg.invert),
		.halves(halves),
		.drive(drive)
	);

	assign output_channel_b_pos = drive.pos;
	assign output_channel_b_neg = drive.neg;
	assign output_channel_b_oe = drive.enable;
	assign output_channel_b_level = drive.level;

endmodule

// ==== output_channel_divider_properties.sv ====
`timescale 1ns/1ps
module output_channel_divider_properties (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [1:0] output_channel_b_pos,
	input wire logic [1:0] output_channel_b_neg,
	input wire logic output_channel_b_oe,
	input wire logic [1:0] output_channel_b_level
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////
	// Bus steps
	sequence w_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence b_done;
		s_axi_bvalid && s_axi_bready;
	endsequence
	////////////////////////////////////////
	AST_OFF_QUIET: assert property (output_channel_b_level == 2'h3 |->
		!output_channel_b_oe && output_channel_b_pos == 2'h0 && output_channel_b_neg == 2'h0)
		else $error("driver active while powered down");
	AST_PAIR: assert property (output_channel_b_oe |->
		output_channel_b_neg == ~output_channel_b_pos)
		else $error("outputs not complementary");
	AST_W_ANSWER: assert property (w_taken |-> ##2 s_axi_bvalid)
		else $error("write response late");
	AST_W_DROP: assert property (w_taken |=> !s_axi_awready && !s_axi_wready)
		else $error("write ready stayed high");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	AST_B_RELEASE: assert property (b_done |=> !s_axi_bvalid &&
		s_axi_awready && s_axi_wready)
		else $error("write channel not rearmed");
	AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid && !s_axi_arready)
		else $error("read data late");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
endmodule
bind output_channel_divider output_channel_divider_properties u_props (.aclk, .aresetn,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
	.output_channel_b_pos, .output_channel_b_neg, .output_channel_b_oe, .output_channel_b_level);

// ==== output_channel_divider_tb_top.sv ====
`timescale 1ns/1ps
module output_channel_divider_tb_top import output_channel_pkg::*;;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic sync_reset = 1'h1;
	logic [13:0] s_axi_awaddr = 14'h0, s_axi_araddr = 14'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, output_channel_b_pos, output_channel_b_neg;
	logic [1:0] output_channel_b_level;
	logic output_channel_b_oe;
	logic [31:0] s_axi_rdata;
	logic [11:0] regs [5] = '{idx_output_b_mode_polarity, idx_channel_b_divide_low,
		idx_channel_b_divide_high, idx_channel_b_start_phase, idx_sync_mask};
	logic [31:0] masks [5] = '{32'h7, 32'hff, 32'h3, 32'h3f, 32'h2};
	logic [9:0] rat [4] = '{10'h0, 10'h1, 10'h3ff, 10'h2};
	logic [5:0] ph [4] = '{6'h1, 6'h3f, 6'h5, 6'h2};
	int n_fail = 0, tests_run = 0, cyc = 0, base, lead;
	always #2 aclk = ~aclk;
	output_channel_divider DUT (.aclk, .aresetn, .sync_reset, .s_axi_awaddr, .s_axi_awprot(3'h0),
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .output_channel_b_pos, .output_channel_b_neg,
		.output_channel_b_oe, .output_channel_b_level);
	////////////////////////////////////////
	task automatic results;
		$display("Checks %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			$display("BAD %s expected %h seen %h", what, exp, got);
			n_fail++;
		end
	endtask
	task automatic wr(input logic [11:0] idx, input logic [7:0] d, input int st, input logic [1:0] er);
		logic a, w;
		@(posedge aclk);
		a = 1'h1;
		w = 1'h1;
		s_axi_awaddr <= {idx, 2'h0};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		while (a || w) begin
			@(posedge aclk);
			if (a && s_axi_awready === 1'h1) begin
				a = 1'h0;
				s_axi_awvalid <= 1'h0;
			end
			if (w && s_axi_wready === 1'h1) begin
				w = 1'h0;
				s_axi_wvalid <= 1'h0;
			end
		end
		repeat (st) @(posedge aclk);
		s_axi_bready <= 1'h1;
		do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
		s_axi_bready <= 1'h0;
		chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
	endtask
	task automatic rd(input logic [11:0] idx, input logic [31:0] exp, input int st,
		input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= {idx, 2'h0};
		s_axi_arvalid <= 1'h1;
		do @(posedge aclk); while (s_axi_arready !== 1'h1);
		s_axi_arvalid <= 1'h0;
		repeat (st) @(posedge aclk);
		s_axi_rready <= 1'h1;
		do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
		s_axi_rready <= 1'h0;
		chk("rdata", exp, s_axi_rdata);
		chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
	endtask
	task automatic run_div(input logic [9:0] r, input logic [5:0] p, output int lz);
		logic q [$];
		int i, lo;
		sync_reset <= 1'h1;
		wr(idx_channel_b_divide_low, r[7:0], 0, resp_okay);
		wr(idx_channel_b_divide_high, {6'h0, r[9:8]}, 0, resp_okay);
		wr(idx_channel_b_start_phase, {2'h0, p}, 0, resp_okay);
		repeat (3) @(posedge aclk);
		chk("held pos", 32'h0, {30'h0, output_channel_b_pos});
		sync_reset <= 1'h0;
		repeat (2 * r + 100) begin
			@(posedge aclk);
			q.push_back(output_channel_b_pos[0]);
			q.push_back(output_channel_b_pos[1]);
		end
		for (lz = 0; lz < q.size() && q[lz] !== 1'h1; lz++);
		for (i = lz; i < q.size() && q[i] === 1'h1; i++);
		for (lo = i; lo < q.size() && q[lo] === 1'h0; lo++);
		chk("high halves", r + 1, i - lz);
		chk("low halves", r + 1, lo - i);
	endtask
	////////////////////////////////////////
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			results();
		end
	end
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'h1;
		repeat (2) @(posedge aclk);
		chk("level", 32'h0, {30'h0, output_channel_b_level});
		rd(idx_channel_state, 32'h5, 0, resp_okay);
		foreach (regs[k]) begin
			rd(regs[k], 32'h0, 0, resp_okay);
			wr(regs[k], 8'hff, k, resp_okay);
			rd(regs[k], masks[k], k, resp_okay);
			wr(regs[k], 8'h00, 0, resp_okay);
		end
		wr(12'h000, 8'h5a, 0, resp_slverr);
		rd(12'h000, 32'h0, 0, resp_slverr);
		run_div(10'h2, 6'h0, base);
		foreach (rat[k]) begin
			run_div(rat[k], ph[k], lead);
			chk("lead halves", base + ph[k], lead);
		end
		sync_reset <= 1'h1;
		wr(idx_output_b_mode_polarity, 8'h01, 0, resp_okay);
		repeat (3) @(posedge aclk);
		chk("inverted held", 32'h3, {30'h0, output_channel_b_pos});
		wr(idx_sync_mask, 8'h02, 2, resp_okay);
		lead = 0;
		repeat (40) begin
			@(posedge aclk);
			if (output_channel_b_pos !== 2'h3) lead++;
		end
		chk("masked toggles", 32'h1, {31'h0, lead > 10});
		rd(idx_channel_state, 32'h6, 0, resp_okay);
		for (int m = 0; m < 4; m++) begin
			wr(idx_output_b_mode_polarity, {5'h0, m[1:0], 1'h0}, 0, resp_okay);
			repeat (2) @(posedge aclk);
			chk("level", m, {30'h0, output_channel_b_level});
			chk("enable", m != 3, {31'h0, output_channel_b_oe});
		end
		chk("off pins", 32'h0, {28'h0, output_channel_b_pos, output_channel_b_neg});
		results();
	end
endmodule
